/* File: hdl/cfr_consts.svh */
// constants for the flags, reset and operand-format slice
// What this block does
// - zero flag set when result is zero
// - overflow flag marks arithmetic overflow
// - carry flag: carry, borrow, shifted-out bit
// - carry is bit-op one-bit accumulator
// - reset: vector pc, trace 0, masks 1
// - other flags reset to 0, datapath registers reset to zero
// - operands: bit, bcd, byte, word, long
// - bit ops select bit 0 to 7
// - decimal adjust treats byte as two digits
// - odd word/long address forced even, no error
// - fetch addresses also forced even
// - decoder supports 65 instruction types
// - eight shift and rotate types
// - fourteen bit-manipulation types on bytes
// - peripheral-synchronised transfers unsupported
// - negative flag copies result msb
// - half carry from bit 3, 11 or 27
`ifndef CFR_CONSTS_SVH
`define CFR_CONSTS_SVH
`define CFR_FLAG_C 0
`define CFR_FLAG_V 1
`define CFR_FLAG_Z 2
`define CFR_FLAG_N 3
`define CFR_FLAG_H 5
`define CFR_FLAG_I 7
`define CFR_EXT_TRACE 7
`define CFR_EXT_RESET 8'h7f
`define CFR_EXT_FIXED 8'h78
`define CFR_FLAGS_RESET 8'h80
`define CFR_HALF_B 3
`define CFR_HALF_W 11
`define CFR_HALF_L 27
`define CFR_ADDR_ADD 8'h00
`define CFR_ADDR_BADDR 8'h04
`define CFR_ADDR_NUMTYPES 8'h08
`define CFR_NUM_TYPES 8'h41
`define CFR_NUM_ARITH 8'h13
`define CFR_NUM_LOGIC 8'h04
`define CFR_NUM_SHIFT 8'h08
`define CFR_NUM_BITOP 8'h0e
`endif

/* File: hdl/cfr_pkg.sv */
// types for the flags, reset and operand-format slice
package cfr_pkg;
  typedef enum logic [1:0] {
    CFR_SZ_B = 2'h0,
    CFR_SZ_W = 2'h1,
    CFR_SZ_L = 2'h2
  } cfr_size_t;
  typedef enum logic [4:0] {
    CFR_OP_ADD = 5'h00,
    CFR_OP_SUB = 5'h01,
    CFR_OP_CMP = 5'h02,
    CFR_OP_NEG = 5'h03,
    CFR_OP_AND = 5'h04,
    CFR_OP_OR = 5'h05,
    CFR_OP_XOR = 5'h06,
    CFR_OP_NOT = 5'h07,
    CFR_OP_SHAL = 5'h08,
    CFR_OP_SHAR = 5'h09,
    CFR_OP_SHLL = 5'h0a,
    CFR_OP_SHLR = 5'h0b,
    CFR_OP_ROTL = 5'h0c,
    CFR_OP_ROTR = 5'h0d,
    CFR_OP_ROTXL = 5'h0e,
    CFR_OP_ROTXR = 5'h0f,
    CFR_OP_BLD = 5'h10,
    CFR_OP_BILD = 5'h11,
    CFR_OP_BAND = 5'h12,
    CFR_OP_BIAND = 5'h13,
    CFR_OP_BOR = 5'h14,
    CFR_OP_BIOR = 5'h15,
    CFR_OP_BXOR = 5'h16,
    CFR_OP_BIXOR = 5'h17,
    CFR_OP_DADJ_ADD = 5'h18,
    CFR_OP_DADJ_SUB = 5'h19,
    CFR_OP_PSYNC = 5'h1a,
    CFR_OP_BTST = 5'h1b
  } cfr_op_t;
  typedef enum logic [1:0] {
    CFR_ST_RESET = 2'h0,
    CFR_ST_RUN = 2'h1
  } cfr_state_t;
endpackage

/* File: hdl/cfr_core.sv */
// flags datapath, reset state and address alignment
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "cfr_consts.svh"
module cfr_core #(
  parameter logic [31:0] RESET_VECTOR = 32'h0000_0000
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic op_valid,
  input wire cfr_pkg::cfr_op_t op_code,
  input wire cfr_pkg::cfr_size_t op_size,
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  input wire logic [2:0] bit_sel,
  input wire logic [31:0] mem_addr,
  input wire cfr_pkg::cfr_size_t mem_size,
  input wire logic [31:0] fetch_addr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [31:0] result_q,
  output logic [7:0] flags_q,
  output logic [7:0] ext_ctrl_q,
  output logic [31:0] pc_q,
  output logic [31:0] mem_addr_q,
  output logic [31:0] fetch_addr_q,
  output logic illegal_q
);
  // ==========================================================
  // size masks and operand width
  logic [31:0] msk;
  logic [5:0] msb_i;
  assign msk = (op_size == cfr_pkg::CFR_SZ_B) ? 32'h0000_00ff :
    (op_size == cfr_pkg::CFR_SZ_W) ? 32'h0000_ffff : 32'hffff_ffff;
  assign msb_i = (op_size == cfr_pkg::CFR_SZ_B) ? 6'h07 :
    (op_size == cfr_pkg::CFR_SZ_W) ? 6'h0f : 6'h1f;
  logic [5:0] hb_i;
  assign hb_i = (op_size == cfr_pkg::CFR_SZ_B) ? 6'(`CFR_HALF_B) :
    (op_size == cfr_pkg::CFR_SZ_W) ? 6'(`CFR_HALF_W) :
    6'(`CFR_HALF_L);
  logic [31:0] a_m, b_m;
  assign a_m = op_a & msk;
  assign b_m = op_b & msk;
  // ==========================================================
  // arithmetic, with carry chain visible per bit
  logic is_sub, is_neg;
  assign is_neg = op_code == cfr_pkg::CFR_OP_NEG;
  assign is_sub = (op_code == cfr_pkg::CFR_OP_SUB) ||
    (op_code == cfr_pkg::CFR_OP_CMP) || is_neg;
  logic [31:0] ax, bx;
  assign ax = is_neg ? 32'h0000_0000 : a_m;
  assign bx = is_neg ? a_m : b_m;
  logic [32:0] cy;
  logic [31:0] sum;
  assign cy[0] = is_sub;
  genvar g;
  for (g = 0; g < 32; g++) begin : g_add
    logic bb;
    assign bb = is_sub ? ~bx[g] : bx[g];
    assign sum[g] = ax[g] ^ bb ^ cy[g];
    assign cy[g + 1] = (ax[g] & bb) | (cy[g] & (ax[g] ^ bb));
  end
  logic [31:0] add_r;
  logic add_c, add_h, add_v;
  assign add_r = sum & msk;
  assign add_c = is_sub ? ~cy[msb_i + 6'h01] : cy[msb_i + 6'h01];
  assign add_h = is_sub ? ~cy[hb_i + 6'h01] : cy[hb_i + 6'h01];
  assign add_v = cy[msb_i + 6'd1] ^ cy[msb_i];
  // ==========================================================
  // shifts and rotates
  logic a_top, a_low;
  assign a_top = a_m[msb_i[4:0]];
  assign a_low = a_m[0];
  logic [31:0] shl, shr_l, shr_a;
  assign shl = (a_m << 1) & msk;
  assign shr_l = a_m >> 1;
  assign shr_a = shr_l | (a_top ? (msk & ~(msk >> 1)) : 32'h0000_0000);
  logic [31:0] topb;
  assign topb = msk & ~(msk >> 1);
  logic [31:0] sh_r;
  logic sh_c, sh_v;
  always_comb begin
    sh_r = shl;
    sh_c = a_top;
    sh_v = 1'b0;
    case (op_code)
      cfr_pkg::CFR_OP_SHAL: begin
        sh_v = a_top ^ a_m[msb_i[4:0] - 5'd1];
      end
      cfr_pkg::CFR_OP_SHAR: begin
        sh_r = shr_a;
        sh_c = a_low;
      end
      cfr_pkg::CFR_OP_SHLR: begin
        sh_r = shr_l;
        sh_c = a_low;
      end
      cfr_pkg::CFR_OP_ROTL: begin
        sh_r = shl | {31'h0000_0000, a_top};
      end
      cfr_pkg::CFR_OP_ROTR: begin
        sh_r = shr_l | (a_low ? topb : 32'h0000_0000);
        sh_c = a_low;
      end
      cfr_pkg::CFR_OP_ROTXL: begin
        sh_r = shl | {31'h0000_0000, flags_q[`CFR_FLAG_C]};
      end
      cfr_pkg::CFR_OP_ROTXR: begin
        sh_r = shr_l | (flags_q[`CFR_FLAG_C] ? topb : 32'h0000_0000);
        sh_c = a_low;
      end
      default: begin
      end
    endcase
  end
  // ==========================================================
  // bit select from byte
  logic sel_bit;
  assign sel_bit = op_a[bit_sel];
  logic c_in;
  assign c_in = flags_q[`CFR_FLAG_C];
  logic bit_c;
  always_comb begin
    case (op_code)
      cfr_pkg::CFR_OP_BLD: bit_c = sel_bit;
      cfr_pkg::CFR_OP_BILD: bit_c = ~sel_bit;
      cfr_pkg::CFR_OP_BAND: bit_c = c_in & sel_bit;
      cfr_pkg::CFR_OP_BIAND: bit_c = c_in & ~sel_bit;
      cfr_pkg::CFR_OP_BOR: bit_c = c_in | sel_bit;
      cfr_pkg::CFR_OP_BIOR: bit_c = c_in | ~sel_bit;
      cfr_pkg::CFR_OP_BXOR: bit_c = c_in ^ sel_bit;
      cfr_pkg::CFR_OP_BIXOR: bit_c = c_in ^ ~sel_bit;
      default: bit_c = c_in;
    endcase
  end
  // ==========================================================
  // decimal adjust, two digits
  logic [3:0] lo_d;
  assign lo_d = op_a[3:0];
  logic adj_lo, adj_hi;
  assign adj_lo = flags_q[`CFR_FLAG_H] || (lo_d > 4'h9);
  assign adj_hi = c_in || (op_a[7:0] > 8'h99);
  logic [7:0] dadj;
  assign dadj = {(adj_hi ? 4'h6 : 4'h0), (adj_lo ? 4'h6 : 4'h0)};
  logic [7:0] dadj_add_r, dadj_sub_r;
  assign dadj_add_r = op_a[7:0] + dadj;
  assign dadj_sub_r = op_a[7:0] - {(c_in ? 4'h6 : 4'h0),
    (flags_q[`CFR_FLAG_H] ? 4'h6 : 4'h0)};
  // ==========================================================
  // result and flag selection
  logic [31:0] res_d;
  logic [7:0] flags_d;
  logic upd_nz, illegal_d;
  logic is_arith, is_logic, is_shift, is_bit, is_dec;
  assign is_arith = op_code <= cfr_pkg::CFR_OP_NEG;
  assign is_logic = (op_code >= cfr_pkg::CFR_OP_AND) &&
    (op_code <= cfr_pkg::CFR_OP_NOT);
  assign is_shift = (op_code >= cfr_pkg::CFR_OP_SHAL) &&
    (op_code <= cfr_pkg::CFR_OP_ROTXR);
  assign is_bit = (op_code >= cfr_pkg::CFR_OP_BLD) &&
    (op_code <= cfr_pkg::CFR_OP_BIXOR);
  assign is_dec = (op_code == cfr_pkg::CFR_OP_DADJ_ADD) ||
    (op_code == cfr_pkg::CFR_OP_DADJ_SUB);
  always_comb begin
    res_d = result_q;
    flags_d = flags_q;
    upd_nz = 1'b1;
    illegal_d = 1'b0;
    if (is_arith) begin
      res_d = add_r;
      flags_d[`CFR_FLAG_C] = add_c;
      flags_d[`CFR_FLAG_V] = add_v;
      flags_d[`CFR_FLAG_H] = add_h;
    end else if (is_logic) begin
      case (op_code)
        cfr_pkg::CFR_OP_AND: res_d = a_m & b_m;
        cfr_pkg::CFR_OP_OR: res_d = a_m | b_m;
        cfr_pkg::CFR_OP_XOR: res_d = a_m ^ b_m;
        default: res_d = ~a_m & msk;
      endcase
      flags_d[`CFR_FLAG_V] = 1'b0;
    end else if (is_shift) begin
      res_d = sh_r;
      flags_d[`CFR_FLAG_C] = sh_c;
      flags_d[`CFR_FLAG_V] = sh_v;
    end else if (is_bit) begin
      flags_d[`CFR_FLAG_C] = bit_c;
      upd_nz = 1'b0;
    end else if (op_code == cfr_pkg::CFR_OP_BTST) begin
      flags_d[`CFR_FLAG_Z] = ~sel_bit;
      upd_nz = 1'b0;
    end else if (is_dec) begin
      res_d = {24'h00_0000, (op_code == cfr_pkg::CFR_OP_DADJ_ADD) ?
        dadj_add_r : dadj_sub_r};
      if (op_code == cfr_pkg::CFR_OP_DADJ_ADD) begin
        flags_d[`CFR_FLAG_C] = adj_hi;
      end
    end else begin
      illegal_d = 1'b1;
      upd_nz = 1'b0;
    end
    if (upd_nz) begin
      flags_d[`CFR_FLAG_Z] = (is_dec ? res_d[7:0] == 8'h00 :
        res_d == 32'h0000_0000);
      flags_d[`CFR_FLAG_N] = is_dec ? res_d[7] : res_d[msb_i[4:0]];
    end
  end
  // ==========================================================
  // odd word/long data address forced even, fetch address always
  logic [31:0] maddr_d, faddr_d;
  assign maddr_d = (mem_size == cfr_pkg::CFR_SZ_B) ? mem_addr :
    {mem_addr[31:1], 1'b0};
  assign faddr_d = {fetch_addr[31:1], 1'b0};
  // ==========================================================
  // register port decode
  logic wr_add, wr_flags;
  assign wr_add = reg_wr && reg_addr == `CFR_ADDR_ADD;
  assign wr_flags = reg_wr && reg_addr == `CFR_ADDR_BADDR;
  logic [31:0] rd_d;
  assign rd_d = (reg_addr == `CFR_ADDR_ADD) ? {24'h00_0000, flags_q} :
    (reg_addr == `CFR_ADDR_BADDR) ? {24'h00_0000, ext_ctrl_q} :
    (reg_addr == `CFR_ADDR_NUMTYPES) ? {`CFR_NUM_BITOP,
    `CFR_NUM_SHIFT, `CFR_NUM_ARITH, `CFR_NUM_TYPES} : 32'h0000_0000;
  // ==========================================================
  // reset exception state
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pc_q <= RESET_VECTOR;
      ext_ctrl_q <= `CFR_EXT_RESET;
      flags_q <= `CFR_FLAGS_RESET;
      illegal_q <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      pc_q <= faddr_d;
      illegal_q <= op_valid && illegal_d;
      reg_rdata <= reg_rd ? rd_d : 32'h0000_0000;
      if (wr_add) begin
        flags_q <= reg_wdata[7:0];
      end else if (op_valid) begin
        flags_q <= flags_d;
      end
      if (wr_flags) begin
        ext_ctrl_q <= reg_wdata[7:0] | `CFR_EXT_FIXED;
      end
    end
  end
  // datapath regs reset-initialised to zero
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      result_q <= 32'h0000_0000;
      mem_addr_q <= 32'h0000_0000;
      fetch_addr_q <= 32'h0000_0000;
    end else begin
      if (op_valid) begin
        result_q <= res_d;
      end
      mem_addr_q <= maddr_d;
      fetch_addr_q <= faddr_d;
    end
  end
  // ==========================================================
  // checks
  AST_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
    op_valid && is_arith && !reg_wr |=>
    flags_q[`CFR_FLAG_Z] == (result_q == 32'h0000_0000))
    else $error("zero flag mismatch");
  AST_OVF: assert property (@(posedge clk_sys) disable iff (!resetn)
    op_valid && is_logic && !reg_wr |=> !flags_q[`CFR_FLAG_V])
    else $error("overflow not cleared");
  AST_CARRY: assert property (@(posedge clk_sys) disable iff (!resetn)
    op_valid && op_code == cfr_pkg::CFR_OP_SHLR && !reg_wr |=>
    flags_q[`CFR_FLAG_C] == $past(op_a[0]))
    else $error("shift carry wrong");
  AST_BLD: assert property (@(posedge clk_sys) disable iff (!resetn)
    op_valid && op_code == cfr_pkg::CFR_OP_BLD && !reg_wr |=>
    flags_q[`CFR_FLAG_C] == $past(sel_bit))
    else $error("bit load carry wrong");
  AST_RESET: assert property (@(posedge clk_sys)
    !resetn |=> flags_q[`CFR_FLAG_I] && ext_ctrl_q[`CFR_EXT_TRACE] == 1'b0
    && pc_q == RESET_VECTOR)
    else $error("reset state wrong");
  AST_MALIGN: assert property (@(posedge clk_sys) disable iff (!resetn)
    mem_size != cfr_pkg::CFR_SZ_B |=> mem_addr_q[0] == 1'b0)
    else $error("odd data address passed");
  AST_FALIGN: assert property (@(posedge clk_sys) disable iff (!resetn)
    1'b1 |=> fetch_addr_q[0] == 1'b0 && pc_q == fetch_addr_q)
    else $error("odd fetch address passed");
  AST_PSYNC: assert property (@(posedge clk_sys) disable iff (!resetn)
    op_valid && op_code == cfr_pkg::CFR_OP_PSYNC |=> illegal_q)
    else $error("unsupported op accepted");
  AST_NEG: assert property (@(posedge clk_sys) disable iff (!resetn)
    op_valid && is_logic && op_size == cfr_pkg::CFR_SZ_B && !reg_wr |=>
    flags_q[`CFR_FLAG_N] == result_q[7])
    else $error("negative flag wrong");
endmodule // cfr_core

/* File: test/tb_top.sv */
// self-checking bench for the flags, reset and alignment core
`timescale 1ns/1ns
module tb_top;
  logic clk_sys;
  logic resetn;
  logic op_valid;
  cfr_pkg::cfr_op_t op_code;
  cfr_pkg::cfr_size_t op_size;
  cfr_pkg::cfr_size_t mem_size;
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [2:0] bit_sel;
  logic [31:0] mem_addr;
  logic [31:0] fetch_addr;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [31:0] result_q;
  logic [7:0] flags_q;
  logic [7:0] ext_ctrl_q;
  logic [31:0] pc_q;
  logic [31:0] mem_addr_q;
  logic [31:0] fetch_addr_q;
  logic illegal_q;
  int err_total;
  int compares;

  cfr_core cfr_core_i (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .op_valid(op_valid),
    .op_code(op_code),
    .op_size(op_size),
    .op_a(op_a),
    .op_b(op_b),
    .bit_sel(bit_sel),
    .mem_addr(mem_addr),
    .mem_size(mem_size),
    .fetch_addr(fetch_addr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .result_q(result_q),
    .flags_q(flags_q),
    .ext_ctrl_q(ext_ctrl_q),
    .pc_q(pc_q),
    .mem_addr_q(mem_addr_q),
    .fetch_addr_q(fetch_addr_q),
    .illegal_q(illegal_q)
  );

  // ==========================================================
  // clock and closing
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic end_of_test;
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // compares
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // access tasks
  task automatic do_op(input logic [4:0] code, input logic [1:0] sz,
      input logic [31:0] a, input logic [31:0] b, input logic [2:0] sel,
      input logic [31:0] er, input logic [7:0] ef, input logic [1:0] m);
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_code <= cfr_pkg::cfr_op_t'(code);
    op_size <= cfr_pkg::cfr_size_t'(sz);
    op_a <= a;
    op_b <= b;
    bit_sel <= sel;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1;
    if (m[1]) chk32(result_q, er);
    if (m[0]) chk8(flags_q, ef);
    chk8({7'h0, illegal_q}, {7'h0, code == 5'h1a || code > 5'h1b});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk32(reg_rdata, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic addr_chk(input logic [31:0] ma, input logic [1:0] sz,
      input logic [31:0] fa, input logic [31:0] em, input logic [31:0] ef);
    @(posedge clk_sys);
    mem_addr <= ma;
    mem_size <= cfr_pkg::cfr_size_t'(sz);
    fetch_addr <= fa;
    @(posedge clk_sys);
    #1;
    chk32(mem_addr_q, em);
    chk32(fetch_addr_q, ef);
    chk32(pc_q, ef);
  endtask

  task automatic reset_chk;
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    chk8(flags_q, 8'h80);
    chk8(ext_ctrl_q, 8'h7f);
    chk32(pc_q, 32'h0);
  endtask

  // ==========================================================
  // tests
  initial begin
    err_total = 0;
    compares = 0;
    resetn = 1'b0;
    op_valid = 1'b0;
    op_code = cfr_pkg::cfr_op_t'(5'h00);
    op_size = cfr_pkg::cfr_size_t'(2'h0);
    mem_size = cfr_pkg::cfr_size_t'(2'h0);
    {op_a, op_b, bit_sel, mem_addr, fetch_addr} = '0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    repeat (20) @(posedge clk_sys);
    reset_chk;
    do_op(5'h00, 2'h0, 32'h7f, 32'h1, 3'h0, 32'h80, 8'haa, 2'h3);
    do_op(5'h00, 2'h0, 32'hff, 32'h1, 3'h0, 32'h0, 8'ha5, 2'h3);
    do_op(5'h01, 2'h0, 32'h0, 32'h1, 3'h0, 32'hff, 8'ha9, 2'h3);
    do_op(5'h00, 2'h1, 32'h800, 32'h800, 3'h0, 32'h1000, 8'ha0, 2'h3);
    do_op(5'h00, 2'h2, 32'h0800_0000, 32'h0800_0000, 3'h0,
          32'h1000_0000, 8'ha0, 2'h3);
    do_op(5'h00, 2'h0, 32'h1, 32'h1, 3'h0, 32'h2, 8'h80, 2'h3);
    do_op(5'h04, 2'h0, 32'hf0, 32'h0f, 3'h0, 32'h0, 8'h84, 2'h3);
    do_op(5'h0a, 2'h0, 32'h81, 32'h0, 3'h0, 32'h2, 8'h81, 2'h3);
    do_op(5'h1b, 2'h0, 32'h0, 32'h0, 3'h5, 32'h0, 8'h85, 2'h1);
    do_op(5'h0b, 2'h0, 32'h1, 32'h0, 3'h0, 32'h0, 8'h85, 2'h3);
    do_op(5'h10, 2'h0, 32'h7f, 32'h0, 3'h7, 32'h0, 8'h84, 2'h1);
    do_op(5'h14, 2'h0, 32'h04, 32'h0, 3'h2, 32'h0, 8'h85, 2'h1);
    do_op(5'h17, 2'h0, 32'h04, 32'h0, 3'h3, 32'h0, 8'h84, 2'h1);
    do_op(5'h00, 2'h0, 32'h09, 32'h1, 3'h0, 32'h0a, 8'h80, 2'h3);
    do_op(5'h18, 2'h0, 32'h0a, 32'h0, 3'h0, 32'h10, 8'h00, 2'h2);
    do_op(5'h01, 2'h0, 32'h10, 32'h1, 3'h0, 32'h0f, 8'ha0, 2'h3);
    do_op(5'h19, 2'h0, 32'h0f, 32'h0, 3'h0, 32'h09, 8'h00, 2'h2);
    do_op(5'h01, 2'h1, 32'h0, 32'h1, 3'h0, 32'hffff, 8'ha9, 2'h3);
    do_op(5'h1a, 2'h0, 32'h5, 32'h5, 3'h0, 32'hffff, 8'ha9, 2'h3);
    do_op(5'h1f, 2'h0, 32'h5, 32'h5, 3'h0, 32'hffff, 8'ha9, 2'h3);
    addr_chk(32'h1001, 2'h1, 32'h4005, 32'h1000, 32'h4004);
    addr_chk(32'h2003, 2'h2, 32'h4006, 32'h2002, 32'h4006);
    addr_chk(32'h3001, 2'h0, 32'h0001, 32'h3001, 32'h0000);
    rd(8'h00, 32'ha9);
    rd(8'h04, 32'h7f);
    rd(8'h08, 32'h0e08_1341);
    rd(8'h0c, 32'h0);
    wr(8'h00, 32'h5a);
    rd(8'h00, 32'h5a);
    chk8(flags_q, 8'h5a);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h78);
    wr(8'h04, 32'h80);
    chk8(ext_ctrl_q, 8'hf8);
    do_op(5'h12, 2'h0, 32'h01, 32'h0, 3'h0, 32'h0, 8'h5a, 2'h1);
    do_op(5'h02, 2'h0, 32'h05, 32'h05, 3'h0, 32'h0, 8'h54, 2'h1);
    do_op(5'h03, 2'h0, 32'h01, 32'h0, 3'h0, 32'hff, 8'h79, 2'h3);
    do_op(5'h05, 2'h0, 32'h80, 32'h01, 3'h0, 32'h81, 8'h79, 2'h3);
    do_op(5'h06, 2'h1, 32'hff, 32'hff, 3'h0, 32'h0, 8'h75, 2'h3);
    do_op(5'h07, 2'h0, 32'h0f, 32'h0, 3'h0, 32'hf0, 8'h79, 2'h3);
    do_op(5'h08, 2'h0, 32'h40, 32'h0, 3'h0, 32'h80, 8'h7a, 2'h3);
    do_op(5'h09, 2'h0, 32'h81, 32'h0, 3'h0, 32'hc0, 8'h79, 2'h3);
    do_op(5'h0c, 2'h0, 32'h81, 32'h0, 3'h0, 32'h03, 8'h71, 2'h3);
    do_op(5'h0d, 2'h0, 32'h01, 32'h0, 3'h0, 32'h80, 8'h79, 2'h3);
    do_op(5'h0e, 2'h0, 32'h00, 32'h0, 3'h0, 32'h01, 8'h70, 2'h3);
    do_op(5'h0f, 2'h0, 32'h01, 32'h0, 3'h0, 32'h00, 8'h75, 2'h3);
    do_op(5'h11, 2'h0, 32'h01, 32'h0, 3'h0, 32'h0, 8'h74, 2'h1);
    do_op(5'h15, 2'h0, 32'h00, 32'h0, 3'h1, 32'h0, 8'h75, 2'h1);
    do_op(5'h13, 2'h0, 32'h02, 32'h0, 3'h1, 32'h0, 8'h74, 2'h1);
    do_op(5'h16, 2'h0, 32'h08, 32'h0, 3'h3, 32'h0, 8'h75, 2'h1);
    reset_chk;
    end_of_test;
  end

  // ==========================================================
  // watchdog
  initial begin
    #100000;
    err_total++;
    end_of_test;
  end
endmodule // tb_top
